// *** verilog/cmac_pkg.sv ***
// constants, encodings and state layout of the cpu mode access control unit
// assumes one core clock and a single ahb-lite master for configuration
package cmac_pkg;

   localparam int unsigned ADDR_W = 16;
   localparam int unsigned PERI_W = 8;

   // cpu modes, gray along boot -> contactless os -> system -> user
   typedef enum logic [2:0]
   {
      MODE_BOOT = 3'h0,
      MODE_COS  = 3'h1,
      MODE_SYS  = 3'h3,
      MODE_USER = 3'h2,
      MODE_TEST = 3'h6
   } cmac_mode_t;

   typedef enum logic [2:0]
   {
      AREA_TEST_ROM = 3'h0,
      AREA_APP_ROM  = 3'h1,
      AREA_COS_EE   = 3'h2,
      AREA_APP_EE   = 3'h3,
      AREA_COS_RAM  = 3'h4,
      AREA_APP_RAM  = 3'h5,
      AREA_PK_RAM   = 3'h6,
      AREA_NONE     = 3'h7
   } cmac_area_t;

   typedef enum logic [1:0]
   {
      OP_READ  = 2'h0,
      OP_WRITE = 2'h1,
      OP_EXEC  = 2'h2
   } cmac_op_t;

   typedef enum logic [2:0]
   {
      GRP_CPU  = 3'h0,
      GRP_SYS  = 3'h1,
      GRP_SEG  = 3'h2,
      GRP_FW   = 3'h3,
      GRP_COS  = 3'h4,
      GRP_TEST = 3'h5,
      GRP_PERI = 3'h6
   } cmac_grp_t;

   typedef enum logic [2:0]
   {
      SEL_NONE   = 3'h0,
      SEL_PSTAT  = 3'h1,
      SEL_CLKSRC = 3'h2,
      SEL_PPTR   = 3'h3,
      SEL_RANDOM = 3'h4,
      SEL_KEY    = 3'h5
   } cmac_sel_t;

   // program_status_high mode field
   localparam int unsigned PSTAT_MODE_LSB = 0;
   localparam logic [1:0]  PSTAT_USER     = 2'h0;
   localparam logic [1:0]  PSTAT_SYS      = 2'h1;
   localparam logic [1:0]  PSTAT_COS      = 2'h2;

   // fixed windows in application rom / eeprom
   localparam logic [ADDR_W-1:0] ACM_BASE     = 16'h7FC0;
   localparam logic [ADDR_W-1:0] ACM_BYTES    = 16'h0040;
   localparam logic [ADDR_W-1:0] SECROW_BASE  = 16'h0000;
   localparam logic [ADDR_W-1:0] SECROW_BYTES = 16'h0040;

   // register byte offsets
   localparam logic [7:0] OFS_PSTAT   = 8'h00;
   localparam logic [7:0] OFS_SEG_TBL = 8'h04;
   localparam logic [7:0] OFS_FW_LO   = 8'h08;
   localparam logic [7:0] OFS_FW_HI   = 8'h0C;
   localparam logic [7:0] OFS_XB_LO   = 8'h10;
   localparam logic [7:0] OFS_XB_HI   = 8'h14;
   localparam logic [7:0] OFS_XS_LO   = 8'h18;
   localparam logic [7:0] OFS_XS_HI   = 8'h1C;
   localparam logic [7:0] OFS_STATUS  = 8'h20;

   // status fields
   localparam int unsigned STAT_MODE_LSB = 0;
   localparam int unsigned STAT_MEM_VIOL = 3;
   localparam int unsigned STAT_SFR_VIOL = 4;

   // reset values
   localparam logic [7:0]  RST_PSTAT   = 8'h00;
   localparam logic [15:0] RST_SEG_TBL = 16'h0000;
   localparam logic [7:0]  RST_FW      = 8'h00;
   localparam logic [7:0]  RST_XCH     = 8'h00;

   typedef struct packed
   {
      logic [7:0]  pstat;
      logic [15:0] seg_tbl;
      logic [7:0]  fw_lo;
      logic [7:0]  fw_hi;
      logic [7:0]  xb_lo;
      logic [7:0]  xb_hi;
      logic [7:0]  xs_lo;
      logic [7:0]  xs_hi;
      cmac_mode_t  mode;
      logic        mem_en;
      logic        mem_viol;
      logic        sfr_rd;
      logic        sfr_wr;
      logic        sfr_viol;
      logic        last_mem_viol;
      logic        last_sfr_viol;
      logic        dp_wr;
      logic [7:0]  dp_ofs;
      logic        rdy;
      logic        resp;
      logic [31:0] rdata;
   } cmac_state_t;

endpackage : cmac_pkg

// *** verilog/cmac_access_ctrl.sv ***
// cpu mode access control: memory and special register access decisions
// assumes cpu requests, segment rights and mode bits arrive on hclk
//
// Notes on behaviour
// - boot: test rom rx, cos eeprom rwx, ram rw
// - test: whole rom rx, eeprom rwx, ram rw
// - cos mode: test rom, cos eeprom/ram
// - system: application rom rx, eeprom rwx, ram rw
// - user rom read/fetch follows segment rights
// - user eeprom each right follows segment entry
// - user ram read/write follows segment entry
// - cos mode reads 64-byte condition area
// - cos mode uses exchange ram window
// - boot or cos reads security row
// - coprocessor reads eeprom, uses own ram
// - boot and test reach every register group except segmentation
// - cos: firewall read, cos rw, firewall-gated peripherals
// - system reaches seg, system, firewall, peripheral groups
// - user peripherals follow fetch segment rights
// - general cpu registers open in every mode
// - status high readable in cos, user
// - clock select readable in cos always
// - segmentation registers only in system mode
// - protected pointers never read back
// - random value register is read-only
// - cipher keys are write-only
// - denied read gives zero, write ignored
// - mode from status high plus two bits
// - segment without rights counts as disabled
// - segment table address resets to zero
//
// Our own choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/10ps
module cmac_access_ctrl
   import cmac_pkg::*;
(
   // clock, reset, enable
   input  logic                 hclk,
   input  logic                 hresetn,
   input  logic                 clk_en,
   // ahb-lite slave
   input  logic                 hsel,
   input  logic [31:0]          haddr,
   input  logic [1:0]           htrans,
   input  logic                 hwrite,
   input  logic [2:0]           hsize,
   input  logic [31:0]          hwdata,
   input  logic                 hready,
   output logic [31:0]          hrdata,
   output logic                 hreadyout,
   output logic                 hresp,
   // internal mode bits
   input  logic                 boot_bit,
   input  logic                 test_bit,
   // memory request
   input  logic                 mem_valid,
   input  logic                 mem_pk,
   input  cmac_op_t             mem_op,
   input  cmac_area_t           mem_area,
   input  logic [ADDR_W-1:0]    mem_addr,
   input  logic [2:0]           seg_rights,
   output logic                 mem_enable,
   output logic                 mem_violation,
   // special register request
   input  logic                 sfr_valid,
   input  logic                 sfr_write,
   input  cmac_grp_t            sfr_group,
   input  cmac_sel_t            sfr_sel,
   input  logic [2:0]           sfr_periph,
   input  logic [PERI_W-1:0]    fetch_periph_rights,
   output logic                 sfr_rd_enable,
   output logic                 sfr_wr_enable,
   output logic                 sfr_violation
);

   localparam cmac_state_t RST_STATE = '{
      pstat: RST_PSTAT, seg_tbl: RST_SEG_TBL, fw_lo: RST_FW, fw_hi: RST_FW,
      xb_lo: RST_XCH, xb_hi: RST_XCH, xs_lo: RST_XCH, xs_hi: RST_XCH,
      mode: MODE_BOOT, mem_en: 1'b0, mem_viol: 1'b0, sfr_rd: 1'b0,
      sfr_wr: 1'b0, sfr_viol: 1'b0, last_mem_viol: 1'b0,
      last_sfr_viol: 1'b0, dp_wr: 1'b0, dp_ofs: 8'h00, rdy: 1'b1,
      resp: 1'b0, rdata: 32'h0000_0000};

   cmac_state_t         s_r;
   cmac_state_t         s_nxt;
   logic                ahb_go;
   logic                in_acm;
   logic                in_sec;
   logic                in_xwin;
   logic                seg_ok;
   logic                mem_ok;
   logic [1:0]          sfr_ok;
   logic [ADDR_W-1:0]   xbase;
   logic [ADDR_W-1:0]   xsize;

   // mode decode
   // mode from bits
   function automatic cmac_mode_t decode_mode(logic bb, logic tb, logic [7:0] ps);
      logic [1:0] f;
      f = ps[PSTAT_MODE_LSB +: 2];
      if (bb)
         return MODE_BOOT;
      if (tb)
         return MODE_TEST;
      if (f == PSTAT_SYS)
         return MODE_SYS;
      if (f == PSTAT_COS)
         return MODE_COS;
      return MODE_USER;
   endfunction : decode_mode

   function automatic logic in_range(logic [ADDR_W-1:0] a, logic [ADDR_W-1:0] b,
                                     logic [ADDR_W-1:0] n);
      logic [ADDR_W-1:0] d;
      d = a - b;
      return (a >= b) && (d < n);
   endfunction : in_range

   // memory decision
   function automatic logic mem_rule(cmac_mode_t m, cmac_area_t a, cmac_op_t o,
                                     logic pk, logic acm, logic sec, logic xw, logic sg);
      logic rd;
      logic wr;
      logic ex;
      logic rom_op;
      logic ram_op;
      logic any_op;
      logic res;
      rd = (o == OP_READ);
      wr = (o == OP_WRITE);
      ex = (o == OP_EXEC);
      rom_op = rd | ex;
      ram_op = rd | wr;
      any_op = rd | wr | ex;
      res = 1'b0;
      if (pk)
      begin
         res = ((a == AREA_COS_EE || a == AREA_APP_EE) && rd)
               || (a == AREA_PK_RAM && ram_op);
      end
      else
      begin
         unique case (m)
            MODE_BOOT: res = (a == AREA_TEST_ROM && rom_op) || (a == AREA_COS_EE && any_op)
                             || (a == AREA_COS_RAM && ram_op)
                             || (a == AREA_APP_EE && sec && rd);
            MODE_TEST: res = ((a == AREA_TEST_ROM || a == AREA_APP_ROM) && rom_op)
                             || ((a == AREA_COS_EE || a == AREA_APP_EE) && any_op)
                             || ((a == AREA_COS_RAM || a == AREA_APP_RAM
                                  || a == AREA_PK_RAM) && ram_op);
            MODE_COS:  res = (a == AREA_TEST_ROM && rom_op) || (a == AREA_COS_EE && any_op)
                             || (a == AREA_COS_RAM && ram_op)
                             || (a == AREA_APP_ROM && acm && rd)
                             || (a == AREA_APP_RAM && xw && ram_op)
                             || (a == AREA_APP_EE && sec && rd);
            MODE_SYS:  res = (a == AREA_APP_ROM && rom_op) || (a == AREA_APP_EE && any_op)
                             || (a == AREA_APP_RAM && ram_op);
            MODE_USER: res = sg && ((a == AREA_APP_ROM && rom_op)
                             || (a == AREA_APP_EE && any_op)
                             || (a == AREA_APP_RAM && ram_op));
            default:   res = 1'b0;
         endcase
      end
      return res;
   endfunction : mem_rule

   // special register decision, returns {read ok, write ok}
   function automatic logic [1:0] sfr_rule(cmac_mode_t m, cmac_grp_t g, cmac_sel_t sl,
                                           logic fw_r, logic fw_w, logic usr);
      logic rd;
      logic wr;
      rd = 1'b0;
      wr = 1'b0;
      unique case (m)
         MODE_BOOT, MODE_TEST:
         begin
            rd = 1'b1;
            wr = 1'b1;
         end
         MODE_COS:
         begin
            rd = (g == GRP_FW) || (g == GRP_COS) || (g == GRP_PERI && fw_r)
                 || (g == GRP_SYS && sl == SEL_PSTAT)
                 || (g == GRP_PERI && sl == SEL_CLKSRC);
            wr = (g == GRP_COS) || (g == GRP_PERI && fw_w);
         end
         MODE_SYS:
         begin
            rd = (g == GRP_SEG) || (g == GRP_SYS) || (g == GRP_FW) || (g == GRP_PERI);
            wr = rd;
         end
         MODE_USER:
         begin
            rd = (g == GRP_PERI && usr) || (g == GRP_SYS && sl == SEL_PSTAT);
            wr = (g == GRP_PERI && usr);
         end
         default:
         begin
            rd = 1'b0;
            wr = 1'b0;
         end
      endcase
      if (g == GRP_CPU)
      begin
         rd = 1'b1;
         wr = 1'b1;
      end
      if (g == GRP_SEG && m != MODE_SYS)
      begin
         rd = 1'b0;
         wr = 1'b0;
      end
      if (sl == SEL_PPTR || sl == SEL_KEY)
         rd = 1'b0;
      if (sl == SEL_RANDOM)
         wr = 1'b0;
      return {rd, wr};
   endfunction : sfr_rule

   // config write gate, segmentation only in system mode
   function automatic logic cfg_wr_ok(cmac_mode_t m, logic [7:0] ofs);
      if (ofs == OFS_SEG_TBL)
         return m == MODE_SYS;
      return (m == MODE_SYS) || (m == MODE_BOOT) || (m == MODE_TEST);
   endfunction : cfg_wr_ok

   function automatic logic [31:0] rd_word(cmac_state_t st, logic [7:0] ofs);
      logic [31:0] w;
      w = 32'h0000_0000;
      unique case (ofs)
         OFS_PSTAT:   w[7:0] = st.pstat;
         OFS_SEG_TBL: w[15:0] = (st.mode == MODE_SYS) ? st.seg_tbl : 16'h0000;
         OFS_FW_LO:   w[7:0] = st.fw_lo;
         OFS_FW_HI:   w[7:0] = st.fw_hi;
         OFS_XB_LO:   w[7:0] = st.xb_lo;
         OFS_XB_HI:   w[7:0] = st.xb_hi;
         OFS_XS_LO:   w[7:0] = st.xs_lo;
         OFS_XS_HI:   w[7:0] = st.xs_hi;
         OFS_STATUS:
         begin
            w[STAT_MODE_LSB +: 3] = st.mode;
            w[STAT_MEM_VIOL]      = st.last_mem_viol;
            w[STAT_SFR_VIOL]      = st.last_sfr_viol;
         end
         default:     w = 32'h0000_0000;
      endcase
      return w;
   endfunction : rd_word

   assign ahb_go  = hsel && htrans[1] && hready;
   assign xbase   = {s_r.xb_hi, s_r.xb_lo};
   assign xsize   = {s_r.xs_hi, s_r.xs_lo};
   assign in_acm  = in_range(mem_addr, ACM_BASE, ACM_BYTES);
   assign in_sec  = in_range(mem_addr, SECROW_BASE, SECROW_BYTES);
   assign in_xwin = in_range(mem_addr, xbase, xsize);
   assign seg_ok  = (s_r.seg_tbl != RST_SEG_TBL) && (seg_rights != 3'h0)
                    && (mem_op != 2'h3) && seg_rights[mem_op];
   assign mem_ok  = mem_rule(s_r.mode, mem_area, mem_op, mem_pk, in_acm, in_sec,
                             in_xwin, seg_ok);
   assign sfr_ok  = sfr_rule(s_r.mode, sfr_group, sfr_sel, s_r.fw_lo[sfr_periph],
                             s_r.fw_hi[sfr_periph], fetch_periph_rights[sfr_periph]);

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.mode = decode_mode(boot_bit, test_bit, s_r.pstat);
      s_nxt.rdy = 1'b1;
      s_nxt.resp = 1'b0;
      // data phase write, denied write ignored
      if (s_r.dp_wr && cfg_wr_ok(s_r.mode, s_r.dp_ofs))
      begin
         unique case (s_r.dp_ofs)
            OFS_PSTAT:   s_nxt.pstat = hwdata[7:0];
            OFS_SEG_TBL: s_nxt.seg_tbl = hwdata[15:0];
            OFS_FW_LO:   s_nxt.fw_lo = hwdata[7:0];
            OFS_FW_HI:   s_nxt.fw_hi = hwdata[7:0];
            OFS_XB_LO:   s_nxt.xb_lo = hwdata[7:0];
            OFS_XB_HI:   s_nxt.xb_hi = hwdata[7:0];
            OFS_XS_LO:   s_nxt.xs_lo = hwdata[7:0];
            OFS_XS_HI:   s_nxt.xs_hi = hwdata[7:0];
            default:     s_nxt.pstat = s_r.pstat;
         endcase
      end
      // address phase, read data set up for the data phase
      s_nxt.dp_wr = 1'b0;
      if (ahb_go)
      begin
         s_nxt.dp_wr  = hwrite && (haddr[31:8] == 24'h00_0000);
         s_nxt.dp_ofs = haddr[7:0];
         s_nxt.rdata  = 32'h0000_0000;
         if (!hwrite && haddr[31:8] == 24'h00_0000)
            s_nxt.rdata = rd_word(s_nxt, haddr[7:0]);
      end
      s_nxt.mem_en   = mem_valid && mem_ok;
      s_nxt.mem_viol = mem_valid && !mem_ok;
      if (mem_valid)
         s_nxt.last_mem_viol = !mem_ok;
      s_nxt.sfr_rd   = sfr_valid && !sfr_write && sfr_ok[1];
      s_nxt.sfr_wr   = sfr_valid && sfr_write && sfr_ok[0];
      s_nxt.sfr_viol = sfr_valid && !(sfr_write ? sfr_ok[0] : sfr_ok[1]);
      if (sfr_valid)
         s_nxt.last_sfr_viol = s_nxt.sfr_viol;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         s_r <= RST_STATE;
      else if (clk_en)
         s_r <= s_nxt;
   end

   assign hrdata        = s_r.rdata;
   assign hreadyout     = s_r.rdy;
   assign hresp         = s_r.resp;
   assign mem_enable    = s_r.mem_en;
   assign mem_violation = s_r.mem_viol;
   assign sfr_rd_enable = s_r.sfr_rd;
   assign sfr_wr_enable = s_r.sfr_wr;
   assign sfr_violation = s_r.sfr_viol;

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   chk_boot_mode: assert property (clk_en && boot_bit |=> s_r.mode == MODE_BOOT)
      else $error("boot bit did not select boot mode");
   chk_boot_cos_ee: assert property (clk_en && mem_valid && !mem_pk
      && s_r.mode == MODE_BOOT && mem_area == AREA_COS_EE |=> mem_enable)
      else $error("boot access to cos eeprom refused");
   chk_test_ram: assert property (clk_en && mem_valid && !mem_pk
      && s_r.mode == MODE_TEST && mem_area == AREA_APP_RAM && mem_op != OP_EXEC
      |=> mem_enable && !mem_violation)
      else $error("test access to ram refused");
   chk_sys_rom_wr: assert property (clk_en && mem_valid && !mem_pk
      && s_r.mode == MODE_SYS && mem_area == AREA_APP_ROM && mem_op == OP_WRITE
      |=> mem_violation)
      else $error("rom write granted in system mode");
   chk_cos_acm: assert property (clk_en && mem_valid && !mem_pk
      && s_r.mode == MODE_COS && mem_area == AREA_APP_ROM && mem_op == OP_READ
      |=> mem_enable == $past(in_acm))
      else $error("condition area read decided wrong");
   chk_user_seg: assert property (clk_en && mem_valid && !mem_pk
      && s_r.mode == MODE_USER && !seg_ok |=> !mem_enable && mem_violation)
      else $error("user access granted without segment right");
   chk_pk_ram: assert property (clk_en && mem_valid && mem_pk
      && mem_area == AREA_PK_RAM && mem_op == OP_WRITE |=> mem_enable)
      else $error("coprocessor ram write refused");
   chk_viol_excl: assert property (!(mem_enable && mem_violation))
      else $error("memory grant and violation together");
   chk_cpu_grp: assert property (clk_en && sfr_valid && sfr_group == GRP_CPU
      && sfr_sel == SEL_NONE |=> !sfr_violation)
      else $error("cpu group access refused");
   chk_seg_sys: assert property (clk_en && sfr_valid && sfr_group == GRP_SEG
      && s_r.mode != MODE_SYS |=> sfr_violation && !sfr_rd_enable && !sfr_wr_enable)
      else $error("segmentation access outside system mode");
   chk_ptr_rd: assert property (clk_en && sfr_valid && !sfr_write
      && sfr_sel == SEL_PPTR |=> !sfr_rd_enable ##0 sfr_violation)
      else $error("protected pointer read back");
   chk_random_wr: assert property (clk_en && sfr_valid && sfr_write
      && sfr_sel == SEL_RANDOM |=> !sfr_wr_enable)
      else $error("random value register written");
   chk_key_rd: assert property (clk_en && sfr_valid && !sfr_write
      && sfr_sel == SEL_KEY |=> !sfr_rd_enable)
      else $error("cipher key read back");

   cov_user_grant: cover property (s_r.mode == MODE_USER && mem_enable);
   cov_cos_xwin: cover property (clk_en && s_r.mode == MODE_COS && in_xwin && mem_valid
      ##1 mem_enable);
   cov_seg_write: cover property (s_r.dp_wr && s_r.dp_ofs == OFS_SEG_TBL
      && s_r.mode == MODE_SYS);
   cov_sfr_deny: cover property (sfr_violation);

endmodule : cmac_access_ctrl

// *** tb/cmac_cpu_model.sv ***
// cpu core model issuing memory and register requests
// assumes the unit answers one cycle after the taking edge
`timescale 1ns/10ps
module cmac_cpu_model
   import cmac_pkg::*;
(
   // clock
   input  logic              hclk,
   // memory side
   output logic              mem_valid,
   output logic              mem_pk,
   output cmac_op_t          mem_op,
   output cmac_area_t        mem_area,
   output logic [ADDR_W-1:0] mem_addr,
   output logic [2:0]        seg_rights,
   input  logic              mem_enable,
   input  logic              mem_violation,
   // register side
   output logic              sfr_valid,
   output logic              sfr_write,
   output cmac_grp_t         sfr_group,
   output cmac_sel_t         sfr_sel,
   output logic [2:0]        sfr_periph,
   output logic [PERI_W-1:0] fetch_periph_rights,
   input  logic              sfr_rd_enable,
   input  logic              sfr_wr_enable,
   input  logic              sfr_violation
);
   initial
   begin
      {mem_valid, mem_pk, mem_addr, seg_rights, sfr_valid, sfr_write} = '0;
      {sfr_periph, fetch_periph_rights} = '0;
      mem_op    = OP_READ;
      mem_area  = AREA_NONE;
      sfr_group = GRP_CPU;
      sfr_sel   = SEL_NONE;
   end

   // one memory request, address and rights scrambled once taken
   task automatic mem(input logic pk, input cmac_op_t op, input cmac_area_t ar,
      input logic [ADDR_W-1:0] ad, input logic [2:0] rt, output logic [1:0] r);
      @(posedge hclk);
      mem_valid  <= 1'b1;
      mem_pk     <= pk;
      mem_op     <= op;
      mem_area   <= ar;
      mem_addr   <= ad;
      seg_rights <= rt;
      @(posedge hclk);
      mem_valid  <= 1'b0;
      mem_addr   <= ~ad;
      seg_rights <= ~rt;
      @(posedge hclk);
      r = {mem_enable, mem_violation};
   endtask : mem

   // one register request
   task automatic sfr(input logic w, input cmac_grp_t g, input cmac_sel_t sl,
      input logic [2:0] p, input logic [PERI_W-1:0] fr, output logic [2:0] r);
      @(posedge hclk);
      sfr_valid           <= 1'b1;
      sfr_write           <= w;
      sfr_group           <= g;
      sfr_sel             <= sl;
      sfr_periph          <= p;
      fetch_periph_rights <= fr;
      @(posedge hclk);
      sfr_valid  <= 1'b0;
      sfr_write  <= ~w;
      sfr_periph <= ~p;
      @(posedge hclk);
      r = {sfr_rd_enable, sfr_wr_enable, sfr_violation};
   endtask : sfr
endmodule : cmac_cpu_model

// *** tb/tb.sv ***
// testbench of the cpu mode access control unit
// assumes a zero wait state ahb-lite slave and the cpu model beside it
`timescale 1ns/10ps
module tb
   import cmac_pkg::*;
;
   localparam logic [1:0] GNT = 2'h2;
   localparam logic [1:0] DEN = 2'h1;
   localparam logic [2:0] ROK = 3'h4;
   localparam logic [2:0] WOK = 3'h2;
   localparam logic [2:0] VIO = 3'h1;
   logic              hclk, hresetn, clk_en, hsel, hwrite, hready;
   logic [31:0]       haddr, hwdata, hrdata;
   logic [1:0]        htrans;
   logic [2:0]        hsize, seg_rights, sfr_periph;
   logic              hreadyout, hresp, boot_bit, test_bit;
   logic              mem_valid, mem_pk, mem_enable, mem_violation;
   cmac_op_t          mem_op;
   cmac_area_t        mem_area;
   logic [ADDR_W-1:0] mem_addr;
   logic              sfr_valid, sfr_write, sfr_rd_enable, sfr_wr_enable;
   logic              sfr_violation;
   cmac_grp_t         sfr_group;
   cmac_sel_t         sfr_sel;
   logic [PERI_W-1:0] fetch_periph_rights;
   int                fails, checks;

   assign hready = hreadyout;
   cmac_access_ctrl cmac_access_ctrl_inst (.*);
   cmac_cpu_model cmac_cpu_model_inst (.*);

   initial
   begin
      hclk = 1'b0;
      {hresetn, hsel, hwrite, htrans, haddr, hwdata, boot_bit, test_bit} = '0;
      clk_en = 1'b1;
      hsize  = 3'h2;
      fails  = 0;
      checks = 0;
   end
   always #12.5 hclk = ~hclk;

   task automatic conclude;
      if (fails == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : conclude

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= 1'b1;
      haddr  <= {24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= 1'b0;
      haddr  <= {24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      chk(hrdata, e);
      chk({31'h0, hresp}, 32'h0);
   endtask : rd

   task automatic m(input logic pk, input cmac_op_t op, input cmac_area_t ar,
      input logic [ADDR_W-1:0] ad, input logic [2:0] rt, input logic [1:0] e);
      logic [1:0] r;
      cmac_cpu_model_inst.mem(pk, op, ar, ad, rt, r);
      chk({30'h0, r}, {30'h0, e});
   endtask : m

   task automatic s(input logic w, input cmac_grp_t g, input cmac_sel_t sl,
      input logic [2:0] p, input logic [7:0] fr, input logic [2:0] e);
      logic [2:0] r;
      cmac_cpu_model_inst.sfr(w, g, sl, p, fr, r);
      chk({29'h0, r}, {29'h0, e});
   endtask : s

   task automatic setm(input logic b, input logic t);
      @(posedge hclk);
      boot_bit <= b;
      test_bit <= t;
      repeat (2) @(posedge hclk);
   endtask : setm

   initial
   begin
      repeat (4000) @(posedge hclk);
      fails++;
      conclude();
   end

   initial
   begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      rd(OFS_SEG_TBL, 32'h0);
      rd(OFS_STATUS, {29'h0, MODE_USER});
      m(0, OP_READ, AREA_APP_ROM, 16'h0100, 3'h7, DEN);
      setm(1'b1, 1'b0);
      m(0, OP_EXEC, AREA_TEST_ROM, 16'h0000, 3'h0, GNT);
      m(0, OP_WRITE, AREA_TEST_ROM, 16'h0000, 3'h0, DEN);
      m(0, OP_WRITE, AREA_COS_EE, 16'h0010, 3'h0, GNT);
      m(0, OP_EXEC, AREA_COS_RAM, 16'h0010, 3'h0, DEN);
      rd(OFS_STATUS, {29'h1, MODE_BOOT});
      m(0, OP_READ, AREA_APP_EE, SECROW_BASE, 3'h0, GNT);
      s(0, GRP_TEST, SEL_NONE, 3'h0, 8'h00, ROK);
      s(1, GRP_SEG, SEL_NONE, 3'h0, 8'h00, VIO);
      wr(OFS_FW_LO, 32'h04);
      wr(OFS_XB_HI, 32'h01);
      wr(OFS_XS_LO, 32'h10);
      wr(8'h24, 32'h5A);
      rd(8'h24, 32'h0);
      wr(OFS_SEG_TBL, 32'h1234);
      rd(OFS_SEG_TBL, 32'h0);
      wr(OFS_PSTAT, {30'h0, PSTAT_COS});
      setm(1'b0, 1'b1);
      m(0, OP_EXEC, AREA_APP_RAM, 16'h0000, 3'h0, DEN);
      m(0, OP_WRITE, AREA_APP_RAM, 16'h0000, 3'h0, GNT);
      m(0, OP_READ, AREA_APP_ROM, 16'h0100, 3'h0, GNT);
      m(0, OP_WRITE, AREA_APP_EE, 16'h0100, 3'h0, GNT);
      s(1, GRP_SYS, SEL_NONE, 3'h0, 8'h00, WOK);
      setm(1'b0, 1'b0);
      rd(OFS_STATUS, {29'h0, MODE_COS});
      m(0, OP_EXEC, AREA_TEST_ROM, 16'h0000, 3'h0, GNT);
      m(0, OP_WRITE, AREA_APP_EE, 16'h0100, 3'h0, DEN);
      m(0, OP_READ, AREA_APP_ROM, ACM_BASE, 3'h0, GNT);
      m(0, OP_READ, AREA_APP_ROM, 16'h7FFF, 3'h0, GNT);
      m(0, OP_READ, AREA_APP_ROM, 16'h7FBF, 3'h0, DEN);
      m(0, OP_WRITE, AREA_APP_EE, SECROW_BASE, 3'h0, DEN);
      m(0, OP_WRITE, AREA_APP_RAM, 16'h0100, 3'h0, GNT);
      m(0, OP_READ, AREA_APP_RAM, 16'h010F, 3'h0, GNT);
      m(0, OP_WRITE, AREA_APP_RAM, 16'h0110, 3'h0, DEN);
      s(0, GRP_FW, SEL_NONE, 3'h0, 8'h00, ROK);
      s(1, GRP_FW, SEL_NONE, 3'h0, 8'h00, VIO);
      s(1, GRP_COS, SEL_NONE, 3'h0, 8'h00, WOK);
      s(0, GRP_PERI, SEL_NONE, 3'h2, 8'h00, ROK);
      s(1, GRP_PERI, SEL_NONE, 3'h2, 8'h00, VIO);
      s(0, GRP_PERI, SEL_NONE, 3'h5, 8'h00, VIO);
      s(0, GRP_PERI, SEL_CLKSRC, 3'h5, 8'h00, ROK);
      s(0, GRP_SYS, SEL_PSTAT, 3'h0, 8'h00, ROK);
      s(1, GRP_SYS, SEL_PSTAT, 3'h0, 8'h00, VIO);
      s(1, GRP_CPU, SEL_NONE, 3'h0, 8'h00, WOK);
      setm(1'b1, 1'b0);
      wr(OFS_PSTAT, {30'h0, PSTAT_SYS});
      setm(1'b0, 1'b0);
      m(0, OP_EXEC, AREA_APP_ROM, 16'h0100, 3'h0, GNT);
      m(0, OP_WRITE, AREA_APP_RAM, 16'h0200, 3'h0, GNT);
      m(0, OP_READ, AREA_TEST_ROM, 16'h0000, 3'h0, DEN);
      m(0, OP_WRITE, AREA_APP_ROM, 16'h0100, 3'h0, DEN);
      s(1, GRP_SEG, SEL_NONE, 3'h0, 8'h00, WOK);
      s(0, GRP_FW, SEL_NONE, 3'h0, 8'h00, ROK);
      s(0, GRP_PERI, SEL_RANDOM, 3'h0, 8'h00, ROK);
      s(1, GRP_PERI, SEL_RANDOM, 3'h0, 8'h00, VIO);
      s(1, GRP_PERI, SEL_KEY, 3'h0, 8'h00, WOK);
      s(0, GRP_PERI, SEL_KEY, 3'h0, 8'h00, VIO);
      s(0, GRP_SYS, SEL_PPTR, 3'h0, 8'h00, VIO);
      rd(OFS_STATUS, {29'h3, MODE_SYS});
      rd(OFS_SEG_TBL, 32'h0);
      wr(OFS_SEG_TBL, 32'h0040);
      rd(OFS_SEG_TBL, 32'h0040);
      wr(OFS_PSTAT, {30'h0, PSTAT_USER});
      setm(1'b0, 1'b0);
      m(0, OP_READ, AREA_APP_ROM, 16'h0100, 3'h1, GNT);
      m(0, OP_EXEC, AREA_APP_ROM, 16'h0100, 3'h1, DEN);
      m(0, OP_WRITE, AREA_APP_EE, 16'h0100, 3'h2, GNT);
      m(0, OP_READ, AREA_APP_EE, 16'h0100, 3'h2, DEN);
      m(0, OP_WRITE, AREA_APP_RAM, 16'h0100, 3'h1, DEN);
      m(0, OP_READ, AREA_APP_RAM, 16'h0100, 3'h0, DEN);
      s(0, GRP_PERI, SEL_NONE, 3'h2, 8'h04, ROK);
      s(0, GRP_PERI, SEL_NONE, 3'h2, 8'hFB, VIO);
      s(0, GRP_SYS, SEL_PSTAT, 3'h0, 8'h00, ROK);
      s(0, GRP_SEG, SEL_NONE, 3'h0, 8'h00, VIO);
      rd(OFS_SEG_TBL, 32'h0);
      m(1, OP_READ, AREA_APP_EE, 16'h0100, 3'h0, GNT);
      m(1, OP_WRITE, AREA_APP_EE, 16'h0100, 3'h0, DEN);
      m(1, OP_WRITE, AREA_PK_RAM, 16'h0010, 3'h0, GNT);
      conclude();
   end
endmodule : tb
